// File: pkg/padec_consts.svh
// padec_consts.svh: address map, field positions and reset figures of the decoder
// assumes a 32-bit byte address and a single 50 MHz core clock
`ifndef PADEC_CONSTS_SVH
`define PADEC_CONSTS_SVH

`define PADEC_PART_HI        31
`define PADEC_PART_LO        30
`define PADEC_BLK256_HI      29
`define PADEC_BLK256_LO      28
`define PADEC_BANK128_HI     29
`define PADEC_BANK128_LO     27
`define PADEC_ALIAS_BIT      26
`define PADEC_PART_STATIC    2'h0
`define PADEC_PART_VLIO      2'h1
`define PADEC_PART_REGS      2'h2
`define PADEC_PART_DRAM      2'h3
`define PADEC_BOOT_ADDR      32'h00000000
`define PADEC_SOCK0_BLK      2'h2
`define PADEC_VLIO_LAST_BANK 3'h1
`define PADEC_DRAM_LAST_BANK 3'h3
`define PADEC_FLUSH_BANK     3'h4
`define PADEC_PCC_SUB_HI     27
`define PADEC_PCC_SUB_LO     26
`define PADEC_PCC_SUB_IO     2'h0
`define PADEC_PCC_SUB_ATTR   2'h2

`endif

// File: pkg/padec_pkg.sv
// padec_pkg: types shared by the address decoder and its bench
// assumes padec_consts.svh is included by users that need the figures
package padec_pkg;

  typedef enum logic [3:0] {
    PADEC_SEL_NONE,
    PADEC_SEL_STATIC,
    PADEC_SEL_PCCARD,
    PADEC_SEL_VLIO,
    PADEC_SEL_REGS,
    PADEC_SEL_DRAM,
    PADEC_SEL_FLUSH,
    PADEC_SEL_ABORT
  } padec_region_t;

  typedef enum logic [1:0] {
    PADEC_PCC_IO,
    PADEC_PCC_RSVD,
    PADEC_PCC_ATTR,
    PADEC_PCC_MEM
  } padec_pcc_space_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        burst;
    logic [31:0] addr;
  } padec_req_t;

  typedef struct packed {
    padec_region_t    region;
    logic [3:0]       static_cs;
    logic [1:0]       vlio_cs;
    logic [1:0]       pcc_cs;
    padec_pcc_space_t pcc_space;
    logic [3:0]       reg_blk_cs;
    logic [3:0]       dram_cs;
    logic             abort;
    logic             ext_cycle;
    logic [25:0]      pin_addr;
  } padec_sel_t;

  typedef struct packed {
    logic sync_rom;
    logic rom_32bit;
  } padec_boot_cfg_t;

endpackage : padec_pkg

// File: core/padec_boot_cfg.sv
// padec_boot_cfg: holds boot rom straps and the reset indicator
// assumes strap pins are steady and synchronous while hard reset is low
`timescale 1ns/1ps
`include "padec_consts.svh"

module padec_boot_cfg (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     hard_reset_in_n,
  input  wire logic                     sync_boot_rom_select,
  input  wire logic                     rom_width_select,
  output padec_pkg::padec_boot_cfg_t    cfg,
  output logic                          in_reset,
  output logic                          first_fetch
);

  padec_pkg::padec_boot_cfg_t cfg_reg;
  padec_pkg::padec_boot_cfg_t cfg_next;
  logic                       held_reg;
  logic                       first_reg;

  // straps captured by the clock while hard reset is held, kept afterwards
  wire sampling = ~hard_reset_in_n;
  padec_pkg::padec_boot_cfg_t straps_now;
  assign straps_now = '{sync_rom: sync_boot_rom_select, rom_32bit: rom_width_select};
  assign cfg_next   = sampling ? straps_now : cfg_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_reg   <= '0;
      held_reg  <= 1'b1;
      first_reg <= 1'b0;
    end else begin
      cfg_reg   <= cfg_next;
      held_reg  <= sampling;
      first_reg <= held_reg & ~sampling;
    end
  end

  assign cfg         = cfg_reg;
  assign in_reset    = held_reg | sampling;
  assign first_fetch = first_reg;

endmodule : padec_boot_cfg

// File: core/padec_decoder.sv
// padec_decoder: physical address decoder for the 4 Gbyte space
// assumes requests are synchronous to SYS_CLK; selects are combinational from the address
`timescale 1ns/1ps
`include "padec_consts.svh"

// What this block does
// - four 1 Gbyte partitions chosen by the top two address bits
// - low partition: four 128 Mbyte static bank selects for rom, sram, flash
// - rest of low partition: two 256 Mbyte card sockets, io/memory/attribute
// - bottom static bank is boot rom; strap picks async or sync rom
// - async boot rom is 16-bit when width strap low, else 32-bit
// - bit 26 dropped for static banks; upper 64 Mbyte aliases lower
// - second partition: two 128 Mbyte static or variable latency selects, no sram
// - 768 Mbyte reserved in second partition gives a data abort
// - third partition: four 256 Mbyte on-chip register blocks
// - top partition: four dram bank selects at fixed 128 Mbyte spacing
// - 128 Mbyte flush region reads zero, no external cycle, writes discarded
// - 384 Mbyte reserved at top end gives a data abort
// - while hard reset low: no fetches, reset indicator active, idle bus
// - after hard reset release first fetch goes to address zero, boot rom
// - width strap sampled during hard reset and kept afterwards
module padec_decoder #(
  parameter int N_PARTITIONS   = 4,
  parameter int N_STATIC_BANKS = 4,
  parameter int N_VLIO_BANKS   = 2,
  parameter int N_SOCKETS      = 2,
  parameter int N_REG_BLOCKS   = 4,
  parameter int N_DRAM_BANKS   = 4
) (
  input  wire logic                   SYS_CLK,
  input  wire logic                   RESET,
  input  wire logic                   HARD_RESET_IN_N,
  input  wire logic                   SYNC_BOOT_ROM_SELECT,
  input  wire logic                   ROM_WIDTH_SELECT,
  input  padec_pkg::padec_req_t       REQ,
  output logic                        REQ_READY,
  output padec_pkg::padec_sel_t       SEL,
  output logic                        DATA_ABORT,
  output logic                        ZERO_READ,
  output logic                        FETCH_ADDR_VALID,
  output logic [31:0]                 FETCH_ADDR,
  output padec_pkg::padec_boot_cfg_t  BOOT_CFG,
  output logic                        ROM_BUS_32BIT,
  output logic                        RESET_INDICATOR_OUT_N
);

  padec_pkg::padec_boot_cfg_t cfg;
  padec_pkg::padec_sel_t      sel_next;
  logic                       in_reset;
  logic                       first_fetch;
  logic                       fetch_valid_reg;
  logic                       reset_ind_n_reg;

  padec_boot_cfg u_boot_cfg (
    .clk                  (SYS_CLK),
    .reset                (RESET),
    .hard_reset_in_n      (HARD_RESET_IN_N),
    .sync_boot_rom_select (SYNC_BOOT_ROM_SELECT),
    .rom_width_select     (ROM_WIDTH_SELECT),
    .cfg                  (cfg),
    .in_reset             (in_reset),
    .first_fetch          (first_fetch)
  );

  // address fields
  wire [31:0] a         = REQ.addr;
  wire [1:0]  part      = a[`PADEC_PART_HI:`PADEC_PART_LO];
  wire [2:0]  bank128   = a[`PADEC_BANK128_HI:`PADEC_BANK128_LO];
  wire [1:0]  blk256    = a[`PADEC_BLK256_HI:`PADEC_BLK256_LO];
  wire [1:0]  pcc_sub   = a[`PADEC_PCC_SUB_HI:`PADEC_PCC_SUB_LO];
  wire [1:0]  bank_idx  = bank128[1:0];
  wire        sock_idx  = blk256[0];
  wire        live      = REQ.valid & ~in_reset;

  // one hit per gigabyte partition
  wire [N_PARTITIONS-1:0] part_hit;
  wire                    in_static;
  wire                    in_vlio;
  wire                    in_regs;
  wire                    in_dram;

  genvar g;
  generate
    for (g = 0; g < N_PARTITIONS; g++) begin : g_part
      assign part_hit[g] = (part == 2'(g));
    end
  endgenerate

  assign in_static = part_hit[`PADEC_PART_STATIC];
  assign in_vlio   = part_hit[`PADEC_PART_VLIO];
  assign in_regs   = part_hit[`PADEC_PART_REGS];
  assign in_dram   = part_hit[`PADEC_PART_DRAM];

  // sub-regions inside the static, vlio and dram partitions
  wire st_bank;
  wire st_pcc;
  wire vl_bank;
  wire vl_rsvd;
  wire dr_bank;
  wire dr_flush;
  wire dr_rsvd;

  assign st_bank  = in_static & ~blk256[1];
  assign st_pcc   = in_static & blk256[1];
  assign vl_bank  = in_vlio & (bank128 <= `PADEC_VLIO_LAST_BANK);
  assign vl_rsvd  = in_vlio & ~vl_bank;
  assign dr_bank  = in_dram & (bank128 <= `PADEC_DRAM_LAST_BANK);
  assign dr_flush = in_dram & (bank128 == `PADEC_FLUSH_BANK);
  assign dr_rsvd  = in_dram & ~dr_bank & ~dr_flush;

  // hits qualified by live: reset or an idle request leaves all of them low
  wire hit_static;
  wire hit_pcc;
  wire hit_vlio;
  wire hit_regs;
  wire hit_dram;
  wire hit_flush;
  wire hit_rsvd;

  assign hit_static = live & st_bank;
  assign hit_pcc    = live & st_pcc;
  assign hit_vlio   = live & vl_bank;
  assign hit_regs   = live & in_regs;
  assign hit_dram   = live & dr_bank;
  assign hit_flush  = live & dr_flush;
  assign hit_rsvd   = live & (vl_rsvd | dr_rsvd);

  // each select compares its own bank number, so a gap above the fitted
  // memory still lands on the fixed bank; software remaps such gaps
  wire [N_STATIC_BANKS-1:0] static_cs_w;
  wire [N_VLIO_BANKS-1:0]   vlio_cs_w;
  wire [N_SOCKETS-1:0]      pcc_cs_w;
  wire [N_REG_BLOCKS-1:0]   reg_blk_cs_w;
  wire [N_DRAM_BANKS-1:0]   dram_cs_w;

  generate
    for (g = 0; g < N_STATIC_BANKS; g++) begin : g_static
      assign static_cs_w[g] = hit_static & (bank_idx == 2'(g));
    end
    for (g = 0; g < N_VLIO_BANKS; g++) begin : g_vlio
      assign vlio_cs_w[g] = hit_vlio & (bank_idx == 2'(g));
    end
    for (g = 0; g < N_SOCKETS; g++) begin : g_sock
      assign pcc_cs_w[g] = hit_pcc & (sock_idx == 1'(g));
    end
    for (g = 0; g < N_REG_BLOCKS; g++) begin : g_regs
      assign reg_blk_cs_w[g] = hit_regs & (blk256 == 2'(g));
    end
    for (g = 0; g < N_DRAM_BANKS; g++) begin : g_dram
      assign dram_cs_w[g] = hit_dram & (bank_idx == 2'(g));
    end
  endgenerate

  // the hits are disjoint, so the order below is only a tie-break for lint
  padec_pkg::padec_region_t region;
  assign region = hit_static ? padec_pkg::PADEC_SEL_STATIC :
                  hit_pcc    ? padec_pkg::PADEC_SEL_PCCARD :
                  hit_vlio   ? padec_pkg::PADEC_SEL_VLIO   :
                  hit_regs   ? padec_pkg::PADEC_SEL_REGS   :
                  hit_dram   ? padec_pkg::PADEC_SEL_DRAM   :
                  hit_flush  ? padec_pkg::PADEC_SEL_FLUSH  :
                  hit_rsvd   ? padec_pkg::PADEC_SEL_ABORT  :
                               padec_pkg::PADEC_SEL_NONE;

  // card subspace: io and attribute quarters as coded, the other two are memory
  wire                         pcc_io;
  wire                         pcc_attr;
  padec_pkg::padec_pcc_space_t pcc_space;

  assign pcc_io    = (pcc_sub == `PADEC_PCC_SUB_IO);
  assign pcc_attr  = (pcc_sub == `PADEC_PCC_SUB_ATTR);
  assign pcc_space = pcc_io   ? padec_pkg::PADEC_PCC_IO   :
                     pcc_attr ? padec_pkg::PADEC_PCC_ATTR :
                                padec_pkg::PADEC_PCC_MEM;

  // flush and reserved hits never start an external cycle
  wire                        is_abort;
  wire                        is_flush;
  wire                        ext_cycle;
  wire [`PADEC_ALIAS_BIT-1:0] pin_addr;

  assign is_abort  = hit_rsvd;
  assign is_flush  = hit_flush;
  assign ext_cycle = live & ~is_abort & ~is_flush;
  // static and card pins carry 26 bits, so bit 26 never leaves: upper half aliases
  assign pin_addr  = a[`PADEC_ALIAS_BIT-1:0];

  assign sel_next = '{
    region:     region,
    static_cs:  static_cs_w,
    vlio_cs:    vlio_cs_w,
    pcc_cs:     pcc_cs_w,
    pcc_space:  pcc_space,
    reg_blk_cs: reg_blk_cs_w,
    dram_cs:    dram_cs_w,
    abort:      is_abort,
    ext_cycle:  ext_cycle,
    pin_addr:   pin_addr
  };

  assign SEL        = sel_next;
  assign DATA_ABORT = is_abort;
  // flush region answers reads with zero data; writes fall on the floor
  assign ZERO_READ  = is_flush & ~REQ.write;
  assign REQ_READY  = ~in_reset;

  // boot width: async rom follows the strap; sync rom always uses the full bus
  assign BOOT_CFG      = cfg;
  assign ROM_BUS_32BIT = cfg.sync_rom | cfg.rom_32bit;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      fetch_valid_reg <= 1'b0;
      reset_ind_n_reg <= 1'b0;
    end else begin
      fetch_valid_reg <= first_fetch;
      reset_ind_n_reg <= ~in_reset;
    end
  end

  assign FETCH_ADDR_VALID      = fetch_valid_reg;
  assign FETCH_ADDR            = `PADEC_BOOT_ADDR;
  assign RESET_INDICATOR_OUT_N = reset_ind_n_reg;

endmodule : padec_decoder

// File: test/padec_decoder_sva.sv
// padec_decoder_sva: port-level checks of the address decoder
// assumes binding onto padec_decoder, one clock domain
`timescale 1ns/1ps
module padec_decoder_sva (
  input wire logic                  SYS_CLK,
  input wire logic                  RESET,
  input wire logic                  HARD_RESET_IN_N,
  input wire logic                  SYNC_BOOT_ROM_SELECT,
  input wire logic                  ROM_WIDTH_SELECT,
  input padec_pkg::padec_req_t      REQ,
  input wire logic                  REQ_READY,
  input padec_pkg::padec_sel_t      SEL,
  input wire logic                  DATA_ABORT,
  input wire logic                  ZERO_READ,
  input wire logic                  FETCH_ADDR_VALID,
  input wire logic [31:0]           FETCH_ADDR,
  input padec_pkg::padec_boot_cfg_t BOOT_CFG,
  input wire logic                  ROM_BUS_32BIT,
  input wire logic                  RESET_INDICATOR_OUT_N
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  wire acc = REQ.valid && REQ_READY;
  wire rsvd = (REQ.addr[31:28] inside {[4'h5:4'h7]}) || (REQ.addr[31:27] > 5'h1C);
  wire [17:0] cs_all = {SEL.static_cs, SEL.vlio_cs, SEL.pcc_cs, SEL.reg_blk_cs, SEL.dram_cs, DATA_ABORT,
    SEL.region == padec_pkg::PADEC_SEL_FLUSH};
  a_abort_map: assert property (acc && rsvd |-> DATA_ABORT && SEL.region == padec_pkg::PADEC_SEL_ABORT)
    else $error("reserved access not aborted");
  a_abort_only: assert property (DATA_ABORT |-> acc && rsvd)
    else $error("abort outside reserved space");
  a_one_select: assert property (acc |-> $onehot(cs_all))
    else $error("not exactly one select");
  a_idle_reset: assert property ((!HARD_RESET_IN_N) [*2] |-> !REQ_READY && !RESET_INDICATOR_OUT_N && cs_all == 18'h0)
    else $error("activity during hard reset");
  a_first_fetch: assert property ($rose(HARD_RESET_IN_N) |-> ##[1:3] FETCH_ADDR_VALID && FETCH_ADDR == 32'h0)
    else $error("no first fetch at zero");
  a_strap_take: assert property ((!HARD_RESET_IN_N) [*2] |=> BOOT_CFG == $past({SYNC_BOOT_ROM_SELECT, ROM_WIDTH_SELECT}))
    else $error("straps not sampled");
  a_hold_cfg: assert property (HARD_RESET_IN_N [*4] |-> $stable(BOOT_CFG))
    else $error("boot config changed after reset");
  a_rom_width: assert property (ROM_BUS_32BIT == (BOOT_CFG.sync_rom || BOOT_CFG.rom_32bit))
    else $error("wrong rom width");
  a_zero_read: assert property (ZERO_READ == (acc && !REQ.write && REQ.addr[31:27] == 5'h1C))
    else $error("zero read mismatch");
  a_flush_quiet: assert property (SEL.region == padec_pkg::PADEC_SEL_FLUSH |-> !SEL.ext_cycle)
    else $error("flush made external cycle");
  a_pin_alias: assert property (acc && SEL.region == padec_pkg::PADEC_SEL_STATIC |-> SEL.pin_addr == REQ.addr[25:0])
    else $error("static pin address wrong");
  c_abort: cover property (DATA_ABORT);
  c_flush: cover property (ZERO_READ);
  c_fetch: cover property (FETCH_ADDR_VALID);
endmodule : padec_decoder_sva

// File: test/padec_core_model.sv
// padec_core_model: requester issuing one access per call
// assumes calls come from one bench process only
`timescale 1ns/1ps
module padec_core_model (
  input  wire logic             clk,
  output padec_pkg::padec_req_t req
);
  initial req = '0;
  // changes only at falling edges; idle address toggles so stale values never match
  task automatic issue(input logic [31:0] a, input logic w, input logic b, input int gap);
    repeat (gap) begin
      @(negedge clk);
      req = '{1'b0, 1'b0, 1'b0, ~req.addr};
    end
    @(negedge clk);
    req = '{1'b1, w, b, a};
    #1;
  endtask : issue
endmodule : padec_core_model

// File: test/padec_decoder_bench.sv
// padec_decoder_bench: self-checking bench of the address decoder
// assumes padec_core_model as requester; checker bound at the foot
`timescale 1ns/1ps
module padec_decoder_bench;
  logic                       sys_clk = 1'b0;
  logic                       reset = 1'b1;
  logic                       hrst_n = 1'b0;
  logic                       srom = 1'b0;
  logic                       wsel = 1'b0;
  logic                       ready, abt, zr, fv, w32, rio_n;
  logic [31:0]                fa;
  padec_pkg::padec_req_t      req;
  padec_pkg::padec_sel_t      sel;
  padec_pkg::padec_boot_cfg_t cfg;
  int                         n_fail = 0;
  int                         cmp_count = 0;
  logic [19:0]                e;
  logic [1:0]                 straps [3] = '{2'h0, 2'h1, 2'h3};
  logic [31:0]                corner [12] = '{32'h0, 32'h0800_0000, 32'h1C00_0000, 32'h2000_0000, 32'h3400_0000,
    32'h4800_0000, 32'h5000_0000, 32'h8000_0000, 32'hB000_0000, 32'hD800_0000, 32'hE000_0000, 32'hE800_0000};
  always #10 sys_clk = ~sys_clk;
  padec_core_model core (.clk(sys_clk), .req(req));
  padec_decoder dut (.SYS_CLK(sys_clk), .RESET(reset), .HARD_RESET_IN_N(hrst_n), .SYNC_BOOT_ROM_SELECT(srom),
    .ROM_WIDTH_SELECT(wsel), .REQ(req), .REQ_READY(ready), .SEL(sel), .DATA_ABORT(abt), .ZERO_READ(zr),
    .FETCH_ADDR_VALID(fv), .FETCH_ADDR(fa), .BOOT_CFG(cfg), .ROM_BUS_32BIT(w32), .RESET_INDICATOR_OUT_N(rio_n));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // packed as region, static, vlio, card, register block, dram selects
  function automatic logic [19:0] exp_sel(input logic [31:0] a);
    logic [2:0] b;
    b = a[29:27];
    case (a[31:30])
      2'h0: exp_sel = (b < 3'h4) ? {4'h1, 4'h1 << b[1:0], 12'h0} : {4'h2, 6'h0, 2'h1 << a[28], 8'h0};
      2'h1: exp_sel = (b < 3'h2) ? {4'h3, 4'h0, 2'h1 << b[0], 10'h0} : {4'h7, 16'h0};
      2'h2: exp_sel = {4'h4, 8'h0, 4'h1 << a[29:28], 4'h0};
      default: exp_sel = (b < 3'h4) ? {4'h5, 12'h0, 4'h1 << b[1:0]} : {(b == 3'h4) ? 4'h6 : 4'h7, 16'h0};
    endcase
  endfunction : exp_sel
  task automatic access(input logic [31:0] a, input logic w);
    core.issue(a, w, 1'($urandom_range(1)), $urandom_range(2));
    e = exp_sel(a);
    chk({sel.region, sel.static_cs, sel.vlio_cs, sel.pcc_cs, sel.reg_blk_cs, sel.dram_cs}, e);
    chk(abt, e[19:16] == 4'h7);
    chk(zr, e[19:16] == 4'h6 && !w);
    chk({sel.abort, sel.ext_cycle}, {e[19:16] == 4'h7, e[19:16] < 4'h6});
    if (e[19:16] == 4'h1) chk(sel.pin_addr, a[25:0]);
    // quarter 1 of a socket counts as memory
    if (e[19:16] == 4'h2) chk(sel.pcc_space, (a[27:26] == 2'h1) ? 2'h3 : a[27:26]);
  endtask : access
  task automatic boot(input logic [1:0] s);
    int i;
    @(negedge sys_clk);
    hrst_n = 1'b0;
    {srom, wsel} = s;
    // hold shortened: settling time is not modelled
    core.issue(32'h0800_0000, 1'b0, 1'b0, 2);
    chk({ready, rio_n, sel.region}, 6'h0);
    hrst_n = 1'b1;
    for (i = 0; i < 8 && fv !== 1'b1; i++) @(negedge sys_clk);
    chk(fv, 1'b1);
    if (fv !== 1'b1) end_sim();
    chk(fa, 32'h0);
    chk(cfg, s);
    chk(w32, |s);
    {srom, wsel} = ~s;
    @(negedge sys_clk);
    chk(fv, 1'b0);
    repeat (3) @(negedge sys_clk);
    chk(cfg, s);
  endtask : boot
  initial begin
    void'($urandom(32'h7F2F));
    repeat (10) @(negedge sys_clk);
    chk({ready, rio_n, fv, cfg, sel.region}, 9'h0);
    reset = 1'b0;
    foreach (straps[k]) boot(straps[k]);
    $display("test boot done");
    foreach (corner[k]) begin
      access(corner[k], 1'b0);
      access(corner[k], 1'b1);
    end
    $display("test corner done");
    repeat (300) access($urandom, 1'($urandom_range(1)));
    $display("test random done");
    end_sim();
  end
endmodule : padec_decoder_bench
bind padec_decoder padec_decoder_sva u_sva (.SYS_CLK, .RESET, .HARD_RESET_IN_N, .SYNC_BOOT_ROM_SELECT,
  .ROM_WIDTH_SELECT, .REQ, .REQ_READY, .SEL, .DATA_ABORT, .ZERO_READ, .FETCH_ADDR_VALID, .FETCH_ADDR, .BOOT_CFG,
  .ROM_BUS_32BIT, .RESET_INDICATOR_OUT_N);
